//--- core/pils_interlock.v
// Hazard detection and stall insertion between decode and execute.
// Assumes decode holds its descriptor steady while stall_o is high and
// presents dec_valid_i for exactly the cycle an instruction is decoded.
// Bus waits add on top of the longest hazard; hazard idles overlap.
// Ages run in clock cycles, so idles already paid shorten later ones.
`timescale 1ns/1ps
`default_nettype none
`include "pils_defs.vh"
module pils_interlock #(
  parameter NUM_SETS = `PILS_NUM_SETS,
  parameter CNT_W = `PILS_CNT_W
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Decoded instruction descriptor
  input wire dec_valid_i,
  input wire dec_arith_i,
  input wire dec_arith_acc_b_i,
  input wire dec_move_src_acc_i,
  input wire dec_move_src_acc_b_i,
  input wire dec_move_dst_acc_i,
  input wire dec_move_dst_acc_b_i,
  input wire dec_sr_move_i,
  input wire dec_sr_bit_i,
  input wire dec_cond_xfer_i,
  input wire dec_ptr_src_i,
  input wire dec_agu_use_i,
  input wire [`PILS_SET_W-1:0] dec_agu_set_i,
  input wire dec_agu_wr_i,
  input wire [`PILS_SET_W-1:0] dec_agu_wr_set_i,
  input wire dec_ext_data_i,
  input wire dec_ext_fetch_i,
  // Bus timing configuration
  input wire [CNT_W-1:0] ext_wait_states_i,
  input wire [CNT_W-1:0] fetch_stall_states_i,
  // Pipeline control
  output wire stall_o,
  output wire exec_start_o,
  output reg [CNT_W-1:0] stall_cnt_o,
  output reg [1:0] agu_hazard_type_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;
  // Hazard type codes reported to the pipeline
  localparam [1:0] HAZ_NONE = 2'd0;
  localparam [1:0] HAZ_ADJ = 2'd1;
  localparam [1:0] HAZ_ONE_GAP = 2'd2;
  localparam [1:0] HAZ_TWO_GAP = 2'd3;

  reg state_q;
  reg state_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  // Previous instruction history
  reg prev_arith_q;
  reg prev_arith_b_q;
  reg prev_mdst_q;
  reg prev_mdst_b_q;
  reg prev_tcc_q;
  reg prev2_arith_q;
  wire [NUM_SETS-1:0] wr_set;
  wire [NUM_SETS*`PILS_AGE_W-1:0] age;
  wire [`PILS_AGE_W-1:0] use_age;
  wire accept;
  wire agu_hit;
  wire need_idle;
  wire last_idle;
  reg [CNT_W-1:0] agu_idle;
  reg [CNT_W-1:0] dalu_idle;
  reg [CNT_W-1:0] total;
  reg [1:0] haz_d;
  // Individual data unit hazards
  wire arith_haz;
  wire xfer_haz;
  wire tcc_haz;
  wire sr_arith;
  wire sr_move_haz;
  wire sr_bit_haz;

  assign accept = dec_valid_i && (state_q == ST_IDLE);
  assign use_age = age[dec_agu_set_i*`PILS_AGE_W +: `PILS_AGE_W];
  // recent write to the used set
  assign agu_hit = dec_agu_use_i && (use_age != `PILS_AGE_WINDOW);

  // Write record is updated when the writing move is accepted
  genvar s;
  generate
    for (s = 0; s < NUM_SETS; s = s + 1) begin : g_wr
      localparam [`PILS_SET_W-1:0] SET_ID = s;
      assign wr_set[s] = accept && dec_agu_wr_i && (dec_agu_wr_set_i == SET_ID);
    end
  endgenerate

  pils_age_track #(
    .NUM_SETS(NUM_SETS)
  ) u_age (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_set_i(wr_set),
    .age_o(age)
  );

  always @* begin
    agu_idle = {CNT_W{1'b0}};
    haz_d = 2'd0;
    // checked as the user is decoded
    if (agu_hit) begin
      case (use_age)
        2'd0: begin
          agu_idle = `PILS_ADJ_IDLE;
          haz_d = HAZ_ADJ;
        end
        2'd1: begin
          agu_idle = `PILS_ONE_GAP_IDLE;
          haz_d = HAZ_ONE_GAP;
        end
        2'd2: begin
          agu_idle = `PILS_TWO_GAP_IDLE;
          haz_d = HAZ_TWO_GAP;
        end
        default: begin
          agu_idle = {CNT_W{1'b0}};
          haz_d = HAZ_NONE;
        end
      endcase
    end
  end

  assign arith_haz = dec_move_src_acc_i && prev_arith_q &&
                     (prev_arith_b_q == dec_move_src_acc_b_i);
  assign xfer_haz = dec_move_src_acc_i && prev_mdst_q &&
                    (prev_mdst_b_q == dec_move_src_acc_b_i);
  assign tcc_haz = dec_ptr_src_i && prev_tcc_q;
  assign sr_arith = prev_arith_q || prev2_arith_q;
  assign sr_move_haz = sr_arith && dec_sr_move_i;
  assign sr_bit_haz = sr_arith && dec_sr_bit_i;

  // Data unit hazards share idle cycles; the longest wins
  always @* begin
    dalu_idle = {CNT_W{1'b0}};
    if ((arith_haz || xfer_haz) && dalu_idle < `PILS_ACC_STALL) begin
      dalu_idle = `PILS_ACC_STALL;
    end
    if (tcc_haz && dalu_idle < `PILS_TCC_STALL) begin
      dalu_idle = `PILS_TCC_STALL;
    end
    if (sr_move_haz && dalu_idle < `PILS_SR_MOVE_STALL) begin
      dalu_idle = `PILS_SR_MOVE_STALL;
    end
    if (sr_bit_haz && dalu_idle < `PILS_SR_BIT_STALL) begin
      dalu_idle = `PILS_SR_BIT_STALL;
    end
  end

  // Address and data unit idles overlap, the longest wins; bus waits add on top
  always @* begin
    total = (agu_idle > dalu_idle) ? agu_idle : dalu_idle;
    if (dec_ext_fetch_i) begin
      total = total + fetch_stall_states_i;
    end
    if (dec_ext_data_i) begin
      total = total + ext_wait_states_i;
    end
  end

  // Hold lasts exactly the idle count loaded on accept
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (need_idle) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (last_idle) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // idles advance ages so later users see them
  always @* begin
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (need_idle) begin
          cnt_d = total;
        end
      end
      ST_HOLD: begin
        cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      default: begin
        cnt_d = {CNT_W{1'b0}};
      end
    endcase
  end

  // Pipeline hold state
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Remaining idle count
  always @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Count shown from the same edge that loads the counter
  always @(posedge clk_i) begin
    if (reset_i) begin
      stall_cnt_o <= {CNT_W{1'b0}};
    end else begin
      stall_cnt_o <= cnt_d;
    end
  end

  // History moves only on accepted instructions
  always @(posedge clk_i) begin
    if (reset_i) begin
      prev_arith_q <= 1'b0;
    end else if (accept) begin
      prev_arith_q <= dec_arith_i;
    end
  end

  // Accumulator written by the last arithmetic
  always @(posedge clk_i) begin
    if (reset_i) begin
      prev_arith_b_q <= 1'b0;
    end else if (accept) begin
      prev_arith_b_q <= dec_arith_acc_b_i;
    end
  end

  // Last move wrote an accumulator
  always @(posedge clk_i) begin
    if (reset_i) begin
      prev_mdst_q <= 1'b0;
    end else if (accept) begin
      prev_mdst_q <= dec_move_dst_acc_i;
    end
  end

  // Accumulator written by the last move
  always @(posedge clk_i) begin
    if (reset_i) begin
      prev_mdst_b_q <= 1'b0;
    end else if (accept) begin
      prev_mdst_b_q <= dec_move_dst_acc_b_i;
    end
  end

  // Last instruction was a conditional transfer
  always @(posedge clk_i) begin
    if (reset_i) begin
      prev_tcc_q <= 1'b0;
    end else if (accept) begin
      prev_tcc_q <= dec_cond_xfer_i;
    end
  end

  // Arithmetic two instructions back
  always @(posedge clk_i) begin
    if (reset_i) begin
      prev2_arith_q <= 1'b0;
    end else if (accept) begin
      prev2_arith_q <= prev_arith_q;
    end
  end

  // Hazard type of the last accepted instruction
  always @(posedge clk_i) begin
    if (reset_i) begin
      agu_hazard_type_o <= HAZ_NONE;
    end else if (accept) begin
      agu_hazard_type_o <= haz_d;
    end
  end

  // idles are requested in the cycle the instruction is decoded
  assign need_idle = accept && (total != {CNT_W{1'b0}});
  assign last_idle = (state_q == ST_HOLD) && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
  // Low in the final idle so decode may offer the next instruction in the following cycle
  assign stall_o = need_idle || ((state_q == ST_HOLD) && !last_idle);
  assign exec_start_o = (accept && !need_idle) || last_idle;
endmodule
`default_nettype wire

//--- common/pils_defs.vh
// Constants for the pipeline interlock and stall logic.
// Assumes decode supplies per-instruction hazard descriptors on the core clock.
// Operation
// - An instruction with an external data access is stretched by the programmed wait states.
// - An externally fetched instruction holds the pipeline for the configured fetch stall count.
// - A move reading an accumulator just written by arithmetic is delayed one cycle.
// - A move reading an accumulator just written by a move is delayed one cycle.
// - A status word read after arithmetic in either of two prior instructions waits two (move) or one (bit test).
// - An instruction naming a pointer register as source right after a conditional transfer waits one cycle.
// - Address use of a pointer whose set was written within three prior cycles is a hazard.
// - A write at distance zero inserts three idle cycles.
// - A write at distance one inserts two idle cycles.
// - A write at distance two inserts one idle cycle.
// - Distance is counted in clock cycles, not instructions.
// - Detection happens at decode and idles come before execution starts.
// - Inserted idle cycles count toward the distance seen by later instructions.
`ifndef PILS_DEFS_VH
`define PILS_DEFS_VH
`define PILS_NUM_SETS 8
`define PILS_SET_W 3
`define PILS_AGE_W 2
`define PILS_AGE_WINDOW 2'd3
`define PILS_CNT_W 5
`define PILS_ACC_STALL 5'h01
`define PILS_SR_MOVE_STALL 5'h02
`define PILS_SR_BIT_STALL 5'h01
`define PILS_TCC_STALL 5'h01
`define PILS_ADJ_IDLE 5'h03
`define PILS_ONE_GAP_IDLE 5'h02
`define PILS_TWO_GAP_IDLE 5'h01
`endif

//--- core/pils_age_track.v
// Per-register-set write age record for address generation hazards.
// Assumes one write event per set per cycle at most; runs every cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pils_defs.vh"
module pils_age_track #(
  parameter NUM_SETS = `PILS_NUM_SETS
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Write events, one bit per set
  input wire [NUM_SETS-1:0] wr_set_i,
  // Age of each set, 3 means no recent write
  output wire [NUM_SETS*`PILS_AGE_W-1:0] age_o
);
  genvar g;
  generate
    for (g = 0; g < NUM_SETS; g = g + 1) begin : g_set
      reg [`PILS_AGE_W-1:0] age_q;
      // ages advance every clock, idle or not
      always @(posedge clk_i) begin
        if (reset_i) begin
          age_q <= `PILS_AGE_WINDOW;
        end else if (wr_set_i[g]) begin
          age_q <= {`PILS_AGE_W{1'b0}};
        end else if (age_q != `PILS_AGE_WINDOW) begin
          age_q <= age_q + 2'd1;
        end
      end
      assign age_o[g*`PILS_AGE_W +: `PILS_AGE_W] = age_q;
    end
  endgenerate
endmodule
`default_nettype wire

//--- bench/pils_decode_model.sv
// Decode-stage model: offers one descriptor and waits for its start.
// Assumes exec_i is the interlock start pulse, settled mid-cycle.
`timescale 1ns/1ps
`default_nettype none
module pils_decode_model (
  // Clock and start pulse
  input wire logic clk_i, exec_i,
  // Descriptor and bus timing
  output logic valid_o,
  output logic [19:0] desc_o,
  output logic [4:0] wait_o, fetch_o
);
  initial begin
    valid_o = 1'b0;
    desc_o = 20'h00000;
    wait_o = 5'h02;
    fetch_o = 5'h03;
  end
  // Held until start; bounded so a hang shows as a count
  task automatic issue(input logic [19:0] d, output logic [4:0] n);
    n = 5'h00;
    @(posedge clk_i);
    desc_o <= d;
    valid_o <= 1'b1;
    repeat (20) begin
      @(negedge clk_i);
      if (exec_i === 1'b1) return;
      n = n + 5'h01;
      @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

//--- bench/pils_interlock_asserts.sv
// Port checker for pils_interlock.
// Assumes a bind onto that module.
`timescale 1ns/1ps
`default_nettype none
module pils_chk #(parameter CNT_W = 5) (
  // Clock, reset, descriptor
  input wire logic clk_i, reset_i, dec_valid_i, dec_move_src_acc_i,
  input wire logic dec_sr_move_i, dec_sr_bit_i, dec_ptr_src_i, dec_agu_use_i,
  input wire logic dec_ext_data_i, dec_ext_fetch_i,
  input wire logic [CNT_W-1:0] ext_wait_states_i, fetch_stall_states_i,
  // Control
  input wire logic [CNT_W-1:0] stall_cnt_o,
  input wire logic stall_o, exec_start_o
);
  logic held_q;
  always @(posedge clk_i) held_q <= reset_i ? 1'b0 : stall_o;
  wire acc = dec_valid_i & ~held_q;
  wire ext = dec_ext_data_i | dec_ext_fetch_i;
  wire calm = ~(dec_move_src_acc_i | dec_sr_move_i | dec_sr_bit_i | dec_ptr_src_i | dec_agu_use_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_two;
    stall_o[*2] ##1 exec_start_o;
  endsequence
  sequence s_three;
    stall_o[*3] ##1 exec_start_o;
  endsequence
  a_start_now: assert property (dec_valid_i && !stall_o |-> exec_start_o)
    else $error("no start");
  a_stall_blocks: assert property (stall_o |-> !exec_start_o)
    else $error("start in stall");
  a_hold_ends: assert property ($fell(stall_o) |-> exec_start_o)
    else $error("hold end without start");
  a_idle_quiet: assert property (!dec_valid_i |-> !exec_start_o)
    else $error("start without instruction");
  a_wait_two: assert property (acc && calm && dec_ext_data_i && !dec_ext_fetch_i
    && ext_wait_states_i == 5'h02 |-> s_two) else $error("wait length");
  a_fetch_three: assert property (acc && calm && dec_ext_fetch_i && !dec_ext_data_i
    && fetch_stall_states_i == 5'h03 |-> s_three) else $error("fetch stall length");
  a_count_load: assert property (acc && calm && dec_ext_fetch_i && !dec_ext_data_i
    && fetch_stall_states_i == 5'h03 |=> stall_cnt_o == 5'h03) else $error("idle count");
  a_calm_go: assert property (acc && calm && !ext |-> exec_start_o)
    else $error("stall without hazard");
  a_idle_bound: assert property (acc && !ext |-> ##[0:3] exec_start_o)
    else $error("more than three idles");
endmodule
bind pils_interlock pils_chk #(.CNT_W(CNT_W)) pils_chk_i (.*);
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for pils_interlock.
// Assumes pils_decode_model drives every descriptor input.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic valid, stall_o, exec_start_o;
  logic [19:0] d;
  logic [4:0] ws, fs, cnt;
  logic [1:0] typ;
  int err_total = 0, cmp_count = 0, cyc = 0;
  initial forever #2 clk_i = ~clk_i;
  pils_decode_model pils_decode_model_i (.clk_i(clk_i), .exec_i(exec_start_o),
    .valid_o(valid), .desc_o(d), .wait_o(ws), .fetch_o(fs));
  pils_interlock pils_interlock_i (.clk_i(clk_i), .reset_i(reset_i), .dec_valid_i(valid),
    .dec_arith_i(d[0]), .dec_arith_acc_b_i(d[1]), .dec_move_src_acc_i(d[2]),
    .dec_move_src_acc_b_i(d[3]), .dec_move_dst_acc_i(d[4]), .dec_move_dst_acc_b_i(d[5]),
    .dec_sr_move_i(d[6]), .dec_sr_bit_i(d[7]), .dec_cond_xfer_i(d[8]), .dec_ptr_src_i(d[9]),
    .dec_agu_use_i(d[10]), .dec_agu_set_i(d[13:11]), .dec_agu_wr_i(d[14]),
    .dec_agu_wr_set_i(d[17:15]), .dec_ext_data_i(d[18]), .dec_ext_fetch_i(d[19]),
    .ext_wait_states_i(ws), .fetch_stall_states_i(fs), .stall_o(stall_o),
    .exec_start_o(exec_start_o), .stall_cnt_o(cnt), .agu_hazard_type_o(typ));
  task automatic chk(input logic [4:0] s, input logic [4:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic nx(input logic [19:0] x, input logic [4:0] e, input logic [1:0] t);
    logic [4:0] n;
    pils_decode_model_i.issue(x, n);
    chk(n, e);
    // Type loads at the accepting edge, so look one cycle on
    fork
      begin
        @(negedge clk_i);
        chk({3'h0, typ}, {3'h0, t});
      end
    join_none
  endtask
  // Flush history, then p, g spacers, then x
  task automatic op(input logic [19:0] p, input int g, input logic [19:0] x,
                    input logic [4:0] e, input logic [1:0] t);
    logic [4:0] n;
    repeat (3) pils_decode_model_i.issue(20'h00000, n);
    pils_decode_model_i.issue(p, n);
    repeat (g) pils_decode_model_i.issue(20'h00000, n);
    nx(x, e, t);
  endtask
  task automatic t_agu;
    op(20'h04000, 0, 20'h00400, 5'h03, 2'h1);
    nx(20'h00400, 5'h00, 2'h0);
    op(20'h0c000, 1, 20'h00c00, 5'h02, 2'h2);
    op(20'h04000, 2, 20'h00400, 5'h01, 2'h3);
    op(20'h04000, 3, 20'h00400, 5'h00, 2'h0);
    op(20'h0c000, 0, 20'h00400, 5'h00, 2'h0);
    op(20'h04000, 0, 20'h40000, 5'h02, 2'h0);
    nx(20'h00400, 5'h00, 2'h0);
    op(20'h00000, 0, 20'h80000, 5'h03, 2'h0);
    op(20'h00000, 0, 20'hc0000, 5'h05, 2'h0);
    op(20'h04000, 0, 20'h40400, 5'h05, 2'h1);
    $display("address and bus test done");
  endtask
  task automatic t_dalu;
    op(20'h00001, 0, 20'h00004, 5'h01, 2'h0);
    op(20'h00003, 0, 20'h00004, 5'h00, 2'h0);
    op(20'h00030, 0, 20'h0000c, 5'h01, 2'h0);
    op(20'h00001, 0, 20'h00040, 5'h02, 2'h0);
    op(20'h00001, 1, 20'h00040, 5'h02, 2'h0);
    op(20'h00001, 2, 20'h00040, 5'h00, 2'h0);
    op(20'h00001, 0, 20'h00080, 5'h01, 2'h0);
    op(20'h00100, 0, 20'h00200, 5'h01, 2'h0);
    repeat (2) @(posedge clk_i);
    $display("data unit test done");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk(cnt, 5'h00);
    chk({4'h0, stall_o}, 5'h00);
    t_agu;
    t_dalu;
    report_and_stop;
  end
  // Hang guard, far above the expected run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule
`default_nettype wire
